// file: verilog/uhi_ctrl_end.sv
// uhi_ctrl_end: controller end with irq enable/status and sof frame timing
`timescale 1ns/1ps
`default_nettype none
module uhi_ctrl_end
  import uhi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  uhi_bus_if.ctrl bus,
  input wire logic dplus_pin,
  input wire logic dminus_pin,
  input wire logic done_a_evt,
  input wire logic done_b_evt,
  input wire logic resume_evt,
  output logic sof_token,
  output logic [10:0] sof_frame,
  output logic [4:0] sof_crc5,
  output logic manual_sof_a,
  output logic manual_sof_b,
  output logic arm_a,
  output logic arm_b,
  output logic suspend
);
  import uhi_pkg::*;
  logic [7:0] irq_enable_mask;
  logic [7:0] irq_flags;
  logic [7:0] ctrl1;
  logic [7:0] sof_low;
  logic [7:0] sof_high;
  logic [13:0] sof_count;
  logic [10:0] frame_num;
  logic [1:0] dp_sync;
  logic [1:0] dm_sync;
  logic dp_q;
  logic bus_se0_q;
  logic present;

  // ********************************
  // decode
  // ********************************
  wire wr_enable = bus.wr_en && (bus.addr == ADDR_IRQ_ENABLE);
  wire wr_status = bus.wr_en && (bus.addr == ADDR_IRQ_STATUS);
  wire wr_ctrl1 = bus.wr_en && (bus.addr == ADDR_CTRL1);
  wire wr_low = bus.wr_en && (bus.addr == ADDR_SOF_LOW);
  wire wr_high = bus.wr_en && (bus.addr == ADDR_SOF_HIGH);
  // channel b shares channel a field meaning at offset + 8
  wire wr_hc_a = bus.wr_en && (bus.addr == ADDR_HOST_A_CTRL);
  wire wr_hc_b = bus.wr_en && (bus.addr == ADDR_HOST_B_CTRL);
  wire wr_pid_a = bus.wr_en && (bus.addr == ADDR_HOST_A_PID);
  wire wr_pid_b = bus.wr_en && (bus.addr == ADDR_HOST_B_PID);
  wire is_sof_pid = (bus.wr_data[7:4] == PID_SOF[7:4]);

  // ********************************
  // frame timing
  // ********************************
  wire [13:0] sof_reload = {sof_high[5:0], sof_low};
  wire frame_tick = (sof_count == 14'h0000);
  wire sof_armed = ctrl1[BIT_SOF_EN] && arm_a;
  wire [10:0] next_frame = frame_num + 11'h001;

  // crc5 over the 11-bit frame field, lsb first
  function automatic logic [4:0] crc5_of(input logic [10:0] data);
    logic [4:0] crc;
    logic fb;
    crc = CRC5_INIT;
    for (int i = 0; i < 11; i++) begin
      fb = data[i] ^ crc[4];
      crc = {crc[3:0], 1'b0};
      if (fb) crc = crc ^ CRC5_POLY;
    end
    return ~crc;
  endfunction : crc5_of

  // ********************************
  // line sensing
  // ********************************
  // dp_sync[0]/dm_sync[0] only feed the second stage
  wire dp_s = dp_sync[1];
  wire se0_s = !dp_sync[1] && !dm_sync[1];
  wire line_change = (se0_s != bus_se0_q);

  // ********************************
  // status assembly
  // ********************************
  wire [7:0] set_evt;
  assign set_evt[BIT_DONE_A] = done_a_evt;
  assign set_evt[BIT_DONE_B] = done_b_evt;
  assign set_evt[3:2] = 2'b00;
  assign set_evt[BIT_SOF_TIMER] = frame_tick;
  assign set_evt[BIT_INS_REM] = line_change;
  assign set_evt[BIT_DET_RES] = resume_evt && ctrl1[BIT_SUSPEND];
  assign set_evt[BIT_DPLUS] = 1'b0;
  // set beats clear in the same cycle, mask not involved
  wire [7:0] clr = wr_status ? (bus.wr_data & CLEAR_MASK) : 8'h00;
  wire [7:0] next_flags = (irq_flags & ~clr) | set_evt;

  // bit 6 is the resume flag only under suspend
  wire det_bit = ctrl1[BIT_SUSPEND] ? irq_flags[BIT_DET_RES] : !present;
  // layout of the status byte
  wire [7:0] status_view = {dp_s, det_bit, irq_flags[5:4], 2'b00,
    irq_flags[1:0]};
  // enable bit 6 follows whichever meaning bit 6 carries
  // enable bit 5 gates the insert/remove flag like any other
  wire [7:0] pending = status_view & irq_enable_mask & ENABLE_MASK;
  // level output, falls only once no enabled source remains
  wire next_irq = |pending[6:0];

  wire [7:0] next_rd = (bus.addr == ADDR_IRQ_ENABLE) ? irq_enable_mask :
    (bus.addr == ADDR_IRQ_STATUS) ? status_view :
    (bus.addr == ADDR_CTRL1) ? ctrl1 :
    (bus.addr == ADDR_SOF_HIGH) ? {2'b00, sof_count[13:8]} : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_enable_mask <= RESET_BYTE;
      irq_flags <= RESET_BYTE;
      ctrl1 <= RESET_BYTE;
      sof_low <= SOF_LOW_1MS;
      sof_high <= SOF_HIGH_1MS;
      sof_count <= SOF_COUNT_RESET;
      frame_num <= FRAME_RESET;
      dp_sync <= 2'b00;
      dm_sync <= 2'b00;
      bus_se0_q <= 1'b1;
      present <= 1'b0;
      dp_q <= 1'b0;
      arm_a <= 1'b0;
      arm_b <= 1'b0;
      bus.rd_data <= RESET_BYTE;
      bus.irq_request_pin <= 1'b0;
      sof_token <= 1'b0;
      sof_frame <= FRAME_RESET;
      sof_crc5 <= 5'h00;
      manual_sof_a <= 1'b0;
      manual_sof_b <= 1'b0;
      suspend <= 1'b0;
    end else begin
      dp_sync <= {dp_sync[0], dplus_pin};
      dm_sync <= {dm_sync[0], dminus_pin};
      bus_se0_q <= se0_s;
      dp_q <= dp_s;
      if (line_change) present <= !se0_s;
      // reserved enable bits never store
      if (wr_enable) irq_enable_mask <= bus.wr_data & ENABLE_MASK;
      if (wr_ctrl1) ctrl1 <= bus.wr_data;
      if (wr_low) sof_low <= bus.wr_data;
      if (wr_high) sof_high <= bus.wr_data;
      if (wr_hc_a) arm_a <= bus.wr_data[BIT_ARM];
      if (wr_hc_b) arm_b <= bus.wr_data[BIT_ARM];
      irq_flags <= next_flags;
      // counter runs whether or not tokens go out
      if (frame_tick) begin
        sof_count <= sof_reload;
        frame_num <= next_frame;
      end else begin
        sof_count <= sof_count - 14'h0001;
      end
      // tokens only after enable and arm, fields from hardware
      sof_token <= frame_tick && sof_armed;
      if (frame_tick) begin
        sof_frame <= frame_num;
        sof_crc5 <= crc5_of(frame_num);
      end
      // pid register write of sof sends one token by hand
      manual_sof_a <= wr_pid_a && is_sof_pid;
      manual_sof_b <= wr_pid_b && is_sof_pid;
      bus.rd_data <= next_rd;
      bus.irq_request_pin <= next_irq;
      suspend <= ctrl1[BIT_SUSPEND];
    end
  end
endmodule : uhi_ctrl_end
`default_nettype wire

// file: verilog/uhi_pkg.sv
// uhi_pkg: register offsets, field positions and timing of the irq and sof block
`default_nettype none
package uhi_pkg;
  localparam logic [7:0] ADDR_HOST_A_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HOST_A_PID = 8'h03;
  localparam logic [7:0] ADDR_HOST_B_CTRL = 8'h08;
  localparam logic [7:0] ADDR_HOST_B_PID = 8'h0b;
  localparam logic [7:0] ADDR_CTRL1 = 8'h05;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h06;
  localparam logic [7:0] ADDR_SLAVE_ADDR = 8'h07;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0d;
  localparam logic [7:0] ADDR_SOF_LOW = 8'h0e;
  localparam logic [7:0] ADDR_SOF_HIGH = 8'h0f;
  localparam int BIT_DONE_A = 0;
  localparam int BIT_DONE_B = 1;
  localparam int BIT_SOF_TIMER = 4;
  localparam int BIT_INS_REM = 5;
  localparam int BIT_DET_RES = 6;
  localparam int BIT_DPLUS = 7;
  localparam int BIT_SOF_EN = 0;
  localparam int BIT_SUSPEND = 6;
  localparam int BIT_ARM = 0;
  localparam logic [7:0] ENABLE_MASK = 8'h73;
  localparam logic [7:0] CLEAR_MASK = 8'h73;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] SOF_LOW_1MS = 8'he0;
  localparam logic [7:0] SOF_HIGH_1MS = 8'h2e;
  localparam logic [7:0] PID_SOF = 8'h50;
  localparam logic [13:0] SOF_COUNT_RESET = 14'h2ee0;
  localparam logic [10:0] FRAME_RESET = 11'h000;
  localparam logic [4:0] CRC5_INIT = 5'h1f;
  localparam logic [4:0] CRC5_POLY = 5'h05;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SET_LOW = 5'b00010,
    ST_SET_HIGH = 5'b00100,
    ST_SET_EN = 5'b01000,
    ST_ARM = 5'b10000
  } uhi_seq_t;
endpackage : uhi_pkg
`default_nettype wire

// file: verilog/uhi_bus_if.sv
// uhi_bus_if: cpu register port and irq line joining the two ends
`timescale 1ns/1ps
`default_nettype none
interface uhi_bus_if;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic irq_request_pin;
  modport ctrl (input wr_en, input rd_en, input addr, input wr_data,
    output rd_data, output irq_request_pin);
  modport cpu (output wr_en, output rd_en, output addr, output wr_data,
    input rd_data, input irq_request_pin);
endinterface : uhi_bus_if
`default_nettype wire

// file: verilog/uhi_cpu_end.sv
// uhi_cpu_end: cpu side that starts sof generation and acknowledges flags
`timescale 1ns/1ps
`default_nettype none
module uhi_cpu_end
  import uhi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  uhi_bus_if.cpu bus,
  input wire logic start_sof,
  input wire logic [7:0] sof_low,
  input wire logic [7:0] sof_high,
  input wire logic ack_req,
  input wire logic [7:0] ack_mask,
  output logic busy,
  output logic irq_seen,
  output logic [7:0] last_status
);
  import uhi_pkg::*;
  uhi_seq_t state;
  uhi_seq_t next_state;
  logic ack_pend;
  logic rd_pend;
  logic [7:0] low_q;
  logic [7:0] high_q;

  // sof start walks low, high, enable then arm, one write each
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (start_sof) next_state = ST_SET_LOW;
      ST_SET_LOW: next_state = ST_SET_HIGH;
      ST_SET_HIGH: next_state = ST_SET_EN;
      ST_SET_EN: next_state = ST_ARM;
      ST_ARM: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  wire seq_wr = (state != ST_IDLE);
  wire ack_wr = (state == ST_IDLE) && ack_pend;
  // offset 07h is never addressed in host mode
  wire [7:0] seq_addr = (state == ST_SET_LOW) ? ADDR_SOF_LOW :
    (state == ST_SET_HIGH) ? ADDR_SOF_HIGH :
    (state == ST_SET_EN) ? ADDR_CTRL1 : ADDR_HOST_A_CTRL;
  wire [7:0] seq_data = (state == ST_SET_LOW) ? low_q :
    (state == ST_SET_HIGH) ? high_q :
    (state == ST_SET_EN) ? (8'h01 << BIT_SOF_EN) : (8'h01 << BIT_ARM);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      ack_pend <= 1'b0;
      rd_pend <= 1'b0;
      low_q <= RESET_BYTE;
      high_q <= RESET_BYTE;
      bus.wr_en <= 1'b0;
      bus.rd_en <= 1'b0;
      bus.addr <= RESET_BYTE;
      bus.wr_data <= RESET_BYTE;
      busy <= 1'b0;
      irq_seen <= 1'b0;
      last_status <= RESET_BYTE;
    end else begin
      state <= next_state;
      if (state == ST_IDLE && start_sof) begin
        low_q <= sof_low;
        high_q <= sof_high;
      end
      if (ack_req) ack_pend <= 1'b1;
      else if (ack_wr) ack_pend <= 1'b0;
      bus.wr_en <= seq_wr || ack_wr;
      bus.addr <= seq_wr ? seq_addr : ADDR_IRQ_STATUS;
      // ones clear flags, zeros leave them
      bus.wr_data <= seq_wr ? seq_data : ack_mask;
      bus.rd_en <= 1'b0;
      if (!seq_wr && !ack_wr && bus.irq_request_pin && !rd_pend) begin
        bus.rd_en <= 1'b1;
        bus.addr <= ADDR_IRQ_STATUS;
      end
      rd_pend <= bus.rd_en;
      if (rd_pend) last_status <= bus.rd_data;
      busy <= (next_state != ST_IDLE);
      irq_seen <= bus.irq_request_pin;
    end
  end
endmodule : uhi_cpu_end
`default_nettype wire

// file: verif/uhi_bus_sva.sv
// uhi_bus_sva: concurrent checks on the bus joining the two ends
`timescale 1ns/1ps
`default_nettype none
module uhi_bus_sva
  import uhi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic irq_request_pin
);
  // ****************
  // helper state
  // ****************
  logic [7:0] en_q;
  wire logic wr_ctl;
  assign wr_ctl = wr_en && (addr == ADDR_IRQ_ENABLE ||
    addr == ADDR_IRQ_STATUS || addr == ADDR_CTRL1);
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      en_q <= 8'h00;
    end else if (wr_en && addr == ADDR_IRQ_ENABLE) begin
      en_q <= wr_data & ENABLE_MASK;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ****************
  // properties
  // ****************
  a_sof_start_order: assert property (
    wr_en && addr == ADDR_SOF_LOW |=> wr_en && addr == ADDR_SOF_HIGH
    ##1 wr_en && addr == ADDR_CTRL1 && wr_data[BIT_SOF_EN]
    ##1 wr_en && addr == ADDR_HOST_A_CTRL && wr_data[BIT_ARM])
    else $error("sof start writes out of order");
  a_sof_arm_last: assert property (
    wr_en && addr == ADDR_HOST_A_CTRL && wr_data[BIT_ARM] |->
    $past(wr_en) && $past(addr) == ADDR_CTRL1)
    else $error("arm written without sof enable before it");
  a_slave_addr_unused: assert property (
    !(wr_en && addr == ADDR_SLAVE_ADDR))
    else $error("slave address register written in host mode");
  a_irq_masked_off: assert property (
    en_q == 8'h00 && $past(en_q) == 8'h00 |-> !irq_request_pin)
    else $error("irq raised with every source masked");
  a_irq_level_holds: assert property (
    irq_request_pin && !wr_ctl && !$past(wr_ctl) |=> irq_request_pin)
    else $error("irq dropped with no clear or mask change");
  a_status_rsvd_zero: assert property (
    rd_en && addr == ADDR_IRQ_STATUS |=> rd_data[3:2] == 2'b00)
    else $error("reserved status bits read nonzero");
  a_enable_readback: assert property (
    rd_en && addr == ADDR_IRQ_ENABLE && !wr_en && !$past(wr_en)
    |=> rd_data == en_q)
    else $error("enable mask readback wrong");
  a_ack_one_write: assert property (
    wr_en && addr == ADDR_IRQ_STATUS |=> !(wr_en && addr == ADDR_IRQ_STATUS))
    else $error("acknowledge written twice");
endmodule : uhi_bus_sva
`default_nettype wire

// file: verif/testbench.sv
// testbench: joined ends, plus a controller end driven by the bench
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import uhi_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic start_sof = 1'b0;
  logic ack_req = 1'b0;
  logic [7:0] sof_low = 8'h0f;
  logic [7:0] sof_high = 8'h00;
  logic [7:0] ack_mask = 8'h01;
  logic dp = 1'b0;
  logic dm = 1'b0;
  logic ev_a = 1'b0;
  logic ev_b = 1'b0;
  logic ev_r = 1'b0;
  logic busy, irq_seen, tok, susp2, man2;
  logic [10:0] frame;
  logic [7:0] rd;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  uhi_bus_if bus1 ();
  uhi_bus_if bus2 ();
  always #5 sys_clk = ~sys_clk;
  uhi_cpu_end uhi_cpu_end_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .bus(bus1), .start_sof(start_sof), .sof_low(sof_low),
    .sof_high(sof_high), .ack_req(ack_req), .ack_mask(ack_mask),
    .busy(busy), .irq_seen(irq_seen), .last_status());
  uhi_ctrl_end uhi_ctrl_end_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .bus(bus1), .dplus_pin(dp), .dminus_pin(dm), .done_a_evt(ev_a),
    .done_b_evt(ev_b), .resume_evt(ev_r), .sof_token(tok),
    .sof_frame(frame), .sof_crc5(), .manual_sof_a(), .manual_sof_b(),
    .arm_a(), .arm_b(), .suspend());
  // second end stands alone so the bench can reach every register
  uhi_ctrl_end uhi_ctrl_end_inst_b (.sys_clk(sys_clk), .rst_n(rst_n),
    .bus(bus2), .dplus_pin(dp), .dminus_pin(dm), .done_a_evt(ev_a),
    .done_b_evt(ev_b), .resume_evt(ev_r), .sof_token(), .sof_frame(),
    .sof_crc5(), .manual_sof_a(man2), .manual_sof_b(), .arm_a(),
    .arm_b(), .suspend(susp2));
  uhi_bus_sva uhi_bus_sva_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .wr_en(bus1.wr_en), .rd_en(bus1.rd_en), .addr(bus1.addr),
    .wr_data(bus1.wr_data), .rd_data(bus1.rd_data),
    .irq_request_pin(bus1.irq_request_pin));
  // ****************
  // shared tasks
  // ****************
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr2(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    bus2.wr_en = 1'b1;
    bus2.addr = a;
    bus2.wr_data = d;
    @(negedge sys_clk);
    bus2.wr_en = 1'b0;
  endtask : wr2
  task automatic rd2(input logic [7:0] a);
    @(negedge sys_clk);
    bus2.rd_en = 1'b1;
    bus2.addr = a;
    @(negedge sys_clk);
    bus2.rd_en = 1'b0;
    @(negedge sys_clk);
    rd = bus2.rd_data;
  endtask : rd2
  task automatic evt(input logic [2:0] m);
    @(negedge sys_clk);
    {ev_r, ev_b, ev_a} = m;
    @(negedge sys_clk);
    {ev_r, ev_b, ev_a} = 3'b000;
  endtask : evt
  // ****************
  // scenarios
  // ****************
  task automatic t_enable();
    wr2(ADDR_IRQ_ENABLE, 8'hff);
    rd2(ADDR_IRQ_ENABLE);
    chk(rd, ENABLE_MASK);
    wr2(ADDR_IRQ_ENABLE, 8'h00);
  endtask : t_enable
  task automatic t_done();
    wr2(ADDR_IRQ_ENABLE, 8'h01);
    evt(3'b011);
    rd2(ADDR_IRQ_STATUS);
    chk(rd[1:0], 2'b11);
    chk(bus2.irq_request_pin, 1'b1);
    wr2(ADDR_IRQ_STATUS, 8'h00);
    rd2(ADDR_IRQ_STATUS);
    chk(rd[1:0], 2'b11);
    chk(bus2.irq_request_pin, 1'b1);
    wr2(ADDR_IRQ_STATUS, 8'h01);
    rd2(ADDR_IRQ_STATUS);
    chk(rd[1:0], 2'b10);
    chk(bus2.irq_request_pin, 1'b0);
    wr2(ADDR_IRQ_STATUS, 8'h02);
    wr2(ADDR_IRQ_ENABLE, 8'h00);
  endtask : t_done
  task automatic t_resume();
    wr2(ADDR_CTRL1, 8'h40);
    // suspend output is one register behind the control byte
    @(negedge sys_clk);
    chk(susp2, 1'b1);
    wr2(ADDR_IRQ_ENABLE, 8'h40);
    evt(3'b100);
    rd2(ADDR_IRQ_STATUS);
    chk(rd[6], 1'b1);
    chk(bus2.irq_request_pin, 1'b1);
    wr2(ADDR_IRQ_STATUS, 8'h40);
    rd2(ADDR_IRQ_STATUS);
    chk(bus2.irq_request_pin, 1'b0);
    // mask first: leaving suspend flips bit 6 to the absence level
    wr2(ADDR_IRQ_ENABLE, 8'h00);
    wr2(ADDR_CTRL1, 8'h00);
  endtask : t_resume
  task automatic t_insert();
    wr2(ADDR_IRQ_ENABLE, 8'h20);
    @(negedge sys_clk);
    dp = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd2(ADDR_IRQ_STATUS);
    chk(rd[7], 1'b1);
    chk(rd[6], 1'b0);
    chk(rd[5], 1'b1);
    chk(bus2.irq_request_pin, 1'b1);
    wr2(ADDR_IRQ_STATUS, 8'h20);
    rd2(ADDR_IRQ_STATUS);
    chk(bus2.irq_request_pin, 1'b0);
  endtask : t_insert
  task automatic t_pid();
    wr2(ADDR_HOST_A_PID, PID_SOF);
    chk(man2, 1'b1);
  endtask : t_pid
  task automatic t_pair();
    int n;
    logic [10:0] f0;
    @(negedge sys_clk);
    start_sof = 1'b1;
    @(negedge sys_clk);
    start_sof = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    // the first tick ends the reset-loaded count, later ones use ours
    n = 0;
    while (tok !== 1'b1 && n < 13000) begin
      @(negedge sys_clk);
      n++;
    end
    f0 = frame;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (tok !== 1'b1 && n < 40);
    chk(n, {sof_high[5:0], sof_low} + 14'h0001);
    chk(frame, f0 + 11'h001);
    evt(3'b001);
    chk(uhi_ctrl_end_inst.irq_flags[BIT_DONE_A], 1'b1);
    @(negedge sys_clk);
    ack_req = 1'b1;
    @(negedge sys_clk);
    ack_req = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(uhi_ctrl_end_inst.irq_flags[BIT_DONE_A], 1'b0);
    chk(irq_seen, 1'b0);
  endtask : t_pair
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    bus2.wr_en = 1'b0;
    bus2.rd_en = 1'b0;
    bus2.addr = 8'h00;
    bus2.wr_data = 8'h00;
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    t_enable();
    t_done();
    t_resume();
    t_insert();
    t_pid();
    t_pair();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
